//--- src/fifo_uart_core.sv
// UART core with 128-word FIFOs and fractional baud-rate generator
// Notes on behaviour
// RULE1: Written bytes are queued, framed with start, parity, stop and shifted out.
// RULE2: A receive character begins only on a high-to-low input transition.
// RULE3: Transmit and receive paths each own a 128-word FIFO.
// RULE4: Trigger thresholds are four-bit fields counted in steps of eight words.
// RULE5: Transmit fill at or above its threshold sets status bit 4.
// RULE6: Two read-only registers give the transmit and receive word counts.
// RULE7: Empty flag rises as the last queued word starts transmission.
// RULE8: The FIFO clear bit discards both FIFO contents.
// RULE9: Transmit off finishes the current character, then sends nothing more.
// RULE10: Bits 5 and 4 invert serial output and serial input.
// RULE11: Line idles high, start bit is low, bits sampled near midbit.
// RULE12: Received words keep their status; reading one loads line status.
// RULE13: Each received word gets parity, framing and noise checks.
// RULE14: Receive off stops after the word in progress.
// RULE15: Standard mode takes three samples per bit; disagreement marks noise.
// RULE16: With crystal selected, clock-ready bit 5 sets once clocks settle.
// RULE17: Clock-out pin carries 16x, 8x or 4x baud tick, irregular if fractional.
// RULE18: Clock enable plus crystal bit picks crystal, else external clock.
// RULE19: Reference is input divided by predivider 1..63, times PLL 6/48/96/144. The code only stores this register; the baud generator does not use it.
// RULE20: Baud rate is reference over 16 times integer-plus-sixteenths divisor.
// RULE21: Host keeps divisor low byte at least 1 and reference below 96 MHz.
// RULE22: Baud config bits 5:4 pick 2x or 4x rate with single midbit sample.
// RULE23: Fraction spread by stretching ticks one cycle, fraction times per sixteen.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.svh"

module fifo_uart_core (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [4:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_serial_in,
  output logic            o_serial_out,
  output logic            o_handshake_clock_out_pin,
  output logic            o_clock_settled_flag
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [4:0] os_len(input logic [7:0] cfg);
    os_len = cfg[`B_RATE_4X] ? 5'h04 : (cfg[`B_RATE_2X] ? 5'h08 : 5'h10);
  endfunction : os_len

  function automatic logic [7:0] mask_len(input logic [7:0] d, input logic [1:0] len);
    mask_len = d & (8'hff >> (2'h3 - len));
  endfunction : mask_len

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [7:0]  mode_control_one_r, mode_control_two_r, line_ctrl_r, invert_cfg_r;
  logic [7:0]  fifo_trigger_levels_r, multiplier_predivider_cfg_r, baud_config_r;
  logic [7:0]  divisor_low_byte_r, divisor_high_byte_r, clock_source_select_r;
  logic [7:0]  interrupt_status_r, line_status_r, rd_mux;
  logic [7:0]  tx_mem [0:127];
  logic [10:0] rx_mem [0:127];
  logic [6:0]  tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [7:0]  transmit_fill_count_r, receive_fill_count_r;
  logic        tx_push, tx_pop, rx_push, rx_pop, fifo_clr;
  logic [10:0] rx_word;
  logic [15:0] div;
  logic [16:0] bcnt_r;
  logic [3:0]  acc_r;
  logic        stretch_r, tick_r, run;
  logic [11:0] settle_r;
  uart_pkg::tx_state_t tx_st_r;
  uart_pkg::rx_state_t rx_st_r;
  logic [7:0]  tx_sh_r, rx_sh_r;
  logic [2:0]  tx_bit_r, rx_bit_r;
  logic [4:0]  tx_tk_r, rx_tk_r, os, mid;
  logic        tx_par_r, tx_stop2_r, tx_line_r;
  logic        s1_r, s2_r, s3_r, rx_f_r, rx_prev_r, rx_bit, sa_r, sb_r;
  logic        noise_r, perr_r, smp_ev, smp_v, smp_noise;

  assign div      = {divisor_high_byte_r, divisor_low_byte_r};
  assign os       = os_len(baud_config_r);
  assign mid      = {1'b0, os[4:1]};
  // RULE8 FIFO discard
  assign fifo_clr = mode_control_two_r[`B_FIFO_CLR];
  assign tx_push  = i_wr && i_addr == `A_HOLDING && transmit_fill_count_r != `FIFO_DEPTH;
  assign rx_pop   = i_rd && i_addr == `A_HOLDING && receive_fill_count_r != 8'h00;

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_control_one_r          <= 8'h00;
      mode_control_two_r          <= 8'h00;
      line_ctrl_r                 <= `R_LINE_CTRL;
      invert_cfg_r                <= 8'h00;
      fifo_trigger_levels_r       <= `R_TRIG_LEVELS;
      multiplier_predivider_cfg_r <= `R_MULT_PREDIV;
      baud_config_r               <= 8'h00;
      divisor_low_byte_r          <= `R_DIV_LOW;
      divisor_high_byte_r         <= 8'h00;
      clock_source_select_r       <= `R_CLK_SOURCE;
    end else if (i_wr) begin
      case (i_addr)
        `A_MODE_ONE:    mode_control_one_r          <= i_wdata;
        `A_MODE_TWO:    mode_control_two_r          <= i_wdata;
        `A_LINE_CTRL:   line_ctrl_r                 <= i_wdata;
        `A_INVERT_CFG:  invert_cfg_r                <= i_wdata;
        `A_TRIG_LEVELS: fifo_trigger_levels_r       <= i_wdata;
        // RULE19 reference settings stored
        `A_MULT_PREDIV: multiplier_predivider_cfg_r <= i_wdata;
        `A_BAUD_CFG:    baud_config_r               <= i_wdata;
        `A_DIV_LOW:     divisor_low_byte_r          <= i_wdata;
        `A_DIV_HIGH:    divisor_high_byte_r         <= i_wdata;
        `A_CLK_SOURCE:  clock_source_select_r       <= i_wdata;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    case (i_addr)
      `A_HOLDING:     rd_mux = rx_mem[rx_rp_r][7:0];
      `A_IRQ_STAT:    rd_mux = interrupt_status_r;
      `A_LINE_STAT:   rd_mux = line_status_r;
      `A_SYS_STAT:    rd_mux = {2'h0, o_clock_settled_flag, 5'h00};
      `A_MODE_ONE:    rd_mux = mode_control_one_r;
      `A_MODE_TWO:    rd_mux = mode_control_two_r;
      `A_LINE_CTRL:   rd_mux = line_ctrl_r;
      `A_INVERT_CFG:  rd_mux = invert_cfg_r;
      `A_TRIG_LEVELS: rd_mux = fifo_trigger_levels_r;
      // RULE6 level readout
      `A_TX_LEVEL:    rd_mux = transmit_fill_count_r;
      `A_RX_LEVEL:    rd_mux = receive_fill_count_r;
      `A_MULT_PREDIV: rd_mux = multiplier_predivider_cfg_r;
      `A_BAUD_CFG:    rd_mux = baud_config_r;
      `A_DIV_LOW:     rd_mux = divisor_low_byte_r;
      `A_DIV_HIGH:    rd_mux = divisor_high_byte_r;
      `A_CLK_SOURCE:  rd_mux = clock_source_select_r;
      default:        rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_rdata <= 8'h00;
    else          o_rdata <= i_rd ? (rx_pop || i_addr != `A_HOLDING ? rd_mux : 8'h00) : 8'h00;
  end

  // Read-to-clear status; a set in the clearing cycle wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      interrupt_status_r <= `R_IRQ_STAT;
    end else begin
      interrupt_status_r <= (i_rd && i_addr == `A_IRQ_STAT) ? 8'h00 : interrupt_status_r;
      // RULE5 transmit trigger
      if (fifo_trigger_levels_r[3:0] != 4'h0 &&
          transmit_fill_count_r >= {1'b0, fifo_trigger_levels_r[3:0], 3'h0})
        interrupt_status_r[`B_TX_TRIG_IRQ] <= 1'b1;
      // RULE4 receive trigger
      if (fifo_trigger_levels_r[7:4] != 4'h0 &&
          receive_fill_count_r >= {1'b0, fifo_trigger_levels_r[7:4], 3'h0})
        interrupt_status_r[`B_RX_TRIG_IRQ] <= 1'b1;
      // RULE7 last word started
      if (tx_pop && transmit_fill_count_r == 8'h01)
        interrupt_status_r[`B_TX_EMPTY] <= 1'b1;
      if (rx_pop && receive_fill_count_r == 8'h01)
        interrupt_status_r[`B_RX_EMPTY] <= 1'b1;
    end
  end

  // RULE12 status of word read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)    line_status_r <= 8'h00;
    else if (rx_pop) line_status_r <= {2'h0, rx_mem[rx_rp_r][10], 1'b0,
                                       rx_mem[rx_rp_r][9:8], 2'h0};
  end

  // --------------------------------------------------------------------------
  // FIFOs
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (tx_push) tx_mem[tx_wp_r] <= i_wdata;
    if (rx_push) rx_mem[rx_wp_r] <= rx_word;
  end

  // RULE3 two 128-word FIFOs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_wp_r <= 7'h00;
      tx_rp_r <= 7'h00;
      transmit_fill_count_r <= 8'h00;
      rx_wp_r <= 7'h00;
      rx_rp_r <= 7'h00;
      receive_fill_count_r <= 8'h00;
    end else if (fifo_clr) begin
      tx_wp_r <= 7'h00;
      tx_rp_r <= 7'h00;
      transmit_fill_count_r <= 8'h00;
      rx_wp_r <= 7'h00;
      rx_rp_r <= 7'h00;
      receive_fill_count_r <= 8'h00;
    end else begin
      tx_wp_r <= tx_wp_r + 7'(tx_push);
      tx_rp_r <= tx_rp_r + 7'(tx_pop);
      transmit_fill_count_r <= transmit_fill_count_r + 8'(tx_push) - 8'(tx_pop);
      rx_wp_r <= rx_wp_r + 7'(rx_push);
      rx_rp_r <= rx_rp_r + 7'(rx_pop);
      receive_fill_count_r <= receive_fill_count_r + 8'(rx_push) - 8'(rx_pop);
    end
  end

  // --------------------------------------------------------------------------
  // Clock source and baud generator
  // --------------------------------------------------------------------------
  // RULE16 crystal settle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_r <= 12'h000;
      o_clock_settled_flag <= 1'b0;
    end else begin
      o_clock_settled_flag <= 1'b0;
      if (!clock_source_select_r[`B_CLK_EN] || !clock_source_select_r[`B_XTAL_SEL])
        settle_r <= 12'h000;
      else if (settle_r != 12'(`SETTLE_CYC))
        settle_r <= settle_r + 12'h001;
      else
        o_clock_settled_flag <= 1'b1;
    end
  end

  // RULE18 source select; external clock runs at once
  assign run = clock_source_select_r[`B_CLK_EN] &&
               (!clock_source_select_r[`B_XTAL_SEL] || o_clock_settled_flag);

  // RULE20 tick every divisor cycles
  // RULE23 fraction spread by carry
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bcnt_r <= 17'h00000;
      acc_r <= 4'h0;
      stretch_r <= 1'b0;
      tick_r <= 1'b0;
    end else if (!run) begin
      bcnt_r <= 17'h00000;
      acc_r <= 4'h0;
      stretch_r <= 1'b0;
      tick_r <= 1'b0;
    end else if (bcnt_r + 17'h00001 >= {1'b0, div} + 17'(stretch_r)) begin
      bcnt_r <= 17'h00000;
      {stretch_r, acc_r} <= {1'b0, acc_r} + {1'b0, baud_config_r[3:0]};
      tick_r <= 1'b1;
    end else begin
      bcnt_r <= bcnt_r + 17'h00001;
      tick_r <= 1'b0;
    end
  end

  // RULE17 baud tick on pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_handshake_clock_out_pin <= 1'b0;
    else          o_handshake_clock_out_pin <= clock_source_select_r[`B_CLK_TO_PIN] & tick_r;
  end

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  // RULE9 start only when not disabled
  assign tx_pop = tx_st_r == uart_pkg::TX_IDLE && tick_r && !fifo_clr &&
                  !mode_control_one_r[`B_TX_OFF] && transmit_fill_count_r != 8'h00;

  // RULE1 framing and shifting
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st_r <= uart_pkg::TX_IDLE;
      tx_sh_r <= 8'h00;
      tx_bit_r <= 3'h0;
      tx_tk_r <= 5'h00;
      tx_par_r <= 1'b0;
      tx_stop2_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else if (tx_pop) begin
      tx_st_r <= uart_pkg::TX_START;
      tx_sh_r <= mask_len(tx_mem[tx_rp_r], line_ctrl_r[1:0]);
      tx_par_r <= ^mask_len(tx_mem[tx_rp_r], line_ctrl_r[1:0]) ^ ~line_ctrl_r[`B_PAR_EVEN];
      tx_bit_r <= 3'h0;
      tx_tk_r <= 5'h00;
      tx_stop2_r <= line_ctrl_r[`B_STOP2];
      tx_line_r <= 1'b0;
    end else if (tick_r && tx_st_r != uart_pkg::TX_IDLE) begin
      tx_tk_r <= tx_tk_r + 5'h01;
      if (tx_tk_r == os - 5'h01) begin
        tx_tk_r <= 5'h00;
        unique case (tx_st_r)
          uart_pkg::TX_START, uart_pkg::TX_DATA: begin
            if (tx_st_r == uart_pkg::TX_DATA && tx_bit_r == {1'b1, line_ctrl_r[1:0]}) begin
              tx_st_r <= line_ctrl_r[`B_PAR_EN] ? uart_pkg::TX_PAR : uart_pkg::TX_STOP;
              tx_line_r <= line_ctrl_r[`B_PAR_EN] ? tx_par_r : 1'b1;
            end else begin
              if (tx_st_r == uart_pkg::TX_DATA) tx_bit_r <= tx_bit_r + 3'h1;
              tx_st_r <= uart_pkg::TX_DATA;
              tx_line_r <= tx_sh_r[0];
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            end
          end
          uart_pkg::TX_PAR: begin
            tx_st_r <= uart_pkg::TX_STOP;
            tx_line_r <= 1'b1;
          end
          uart_pkg::TX_STOP: begin
            if (tx_stop2_r) tx_stop2_r <= 1'b0;
            else            tx_st_r <= uart_pkg::TX_IDLE;
          end
          uart_pkg::TX_IDLE: ;
        endcase
      end
    end
  end

  // RULE10 output inversion
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_serial_out <= 1'b1;
    else          o_serial_out <= tx_line_r ^ invert_cfg_r[`B_OUT_INV];
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      rx_f_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      s1_r <= i_serial_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) rx_f_r <= s3_r;
      rx_prev_r <= rx_bit;
    end
  end

  // RULE10 input inversion
  assign rx_bit = rx_f_r ^ invert_cfg_r[`B_IN_INV];

  // RULE11 midbit sampling
  // RULE15 three-sample vote in standard mode
  // RULE22 single sample at 2x and 4x
  always_comb begin
    smp_ev = 1'b0;
    smp_v = rx_bit;
    smp_noise = 1'b0;
    if (tick_r && rx_st_r != uart_pkg::RX_IDLE) begin
      if (os != 5'h10) begin
        smp_ev = rx_tk_r == mid;
      end else begin
        smp_ev = rx_tk_r == mid + 5'h01;
        smp_v = (sa_r & sb_r) | (sa_r & rx_bit) | (sb_r & rx_bit);
        smp_noise = !(sa_r == sb_r && sb_r == rx_bit);
      end
    end
  end

  // RULE13 parity, framing, noise stored
  assign rx_word = {noise_r | smp_noise, !smp_v, perr_r,
                    rx_sh_r >> (2'h3 - line_ctrl_r[1:0])};
  assign rx_push = smp_ev && rx_st_r == uart_pkg::RX_STOP && !fifo_clr &&
                   receive_fill_count_r != `FIFO_DEPTH;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_r <= uart_pkg::RX_IDLE;
      rx_sh_r <= 8'h00;
      rx_bit_r <= 3'h0;
      rx_tk_r <= 5'h00;
      sa_r <= 1'b1;
      sb_r <= 1'b1;
      noise_r <= 1'b0;
      perr_r <= 1'b0;
    end else if (rx_st_r == uart_pkg::RX_IDLE) begin
      // RULE2 falling edge starts
      // RULE14 no new word when off
      if (run && !mode_control_one_r[`B_RX_OFF] && rx_prev_r && !rx_bit) begin
        rx_st_r <= uart_pkg::RX_START;
        rx_tk_r <= 5'h00;
        rx_bit_r <= 3'h0;
        noise_r <= 1'b0;
        perr_r <= 1'b0;
        rx_sh_r <= 8'h00;
      end
    end else if (tick_r) begin
      rx_tk_r <= (rx_tk_r == os - 5'h01) ? 5'h00 : rx_tk_r + 5'h01;
      if (rx_tk_r == mid - 5'h01) sa_r <= rx_bit;
      if (rx_tk_r == mid) sb_r <= rx_bit;
      if (smp_ev) begin
        noise_r <= noise_r | smp_noise;
        unique case (rx_st_r)
          uart_pkg::RX_START: begin
            if (smp_v) rx_st_r <= uart_pkg::RX_IDLE;
            else       rx_st_r <= uart_pkg::RX_DATA;
          end
          uart_pkg::RX_DATA: begin
            rx_sh_r <= {smp_v, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == {1'b1, line_ctrl_r[1:0]})
              rx_st_r <= line_ctrl_r[`B_PAR_EN] ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
          end
          uart_pkg::RX_PAR: begin
            perr_r <= smp_v != (^(rx_sh_r >> (2'h3 - line_ctrl_r[1:0])) ^
                                ~line_ctrl_r[`B_PAR_EVEN]);
            rx_st_r <= uart_pkg::RX_STOP;
          end
          uart_pkg::RX_STOP: rx_st_r <= uart_pkg::RX_IDLE;
          uart_pkg::RX_IDLE: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE3
    transmit_fill_count_r <= `FIFO_DEPTH && receive_fill_count_r <= `FIFO_DEPTH)
    else $error("fifo count above depth");

  a_tx_trig_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
    (fifo_trigger_levels_r[3:0] != 4'h0 &&
     transmit_fill_count_r >= {1'b0, fifo_trigger_levels_r[3:0], 3'h0})
    |=> interrupt_status_r[`B_TX_TRIG_IRQ])
    else $error("transmit trigger flag not set");

  a_level_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    (i_rd && i_addr == `A_TX_LEVEL) |=> o_rdata == $past(transmit_fill_count_r))
    else $error("transmit level readback wrong");

  a_tx_empty_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
    (tx_pop && transmit_fill_count_r == 8'h01)
    |=> interrupt_status_r[`B_TX_EMPTY] && tx_st_r == uart_pkg::TX_START)
    else $error("empty flag missing on last word");

  a_fifo_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE8
    fifo_clr |=> transmit_fill_count_r == 8'h00 && receive_fill_count_r == 8'h00)
    else $error("fifo clear left words");

  a_tx_off_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
    (tx_st_r == uart_pkg::TX_IDLE && mode_control_one_r[`B_TX_OFF])
    |=> tx_st_r == uart_pkg::TX_IDLE ##0 o_serial_out == $past(invert_cfg_r[`B_OUT_INV]) ^ 1'b1)
    else $error("transmitter started while off");

  a_rx_start_edge: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE2
    (rx_st_r == uart_pkg::RX_IDLE && !(rx_prev_r && !rx_bit)) |=> rx_st_r == uart_pkg::RX_IDLE)
    else $error("receiver started without falling edge");

  a_rx_off_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE14
    (rx_st_r == uart_pkg::RX_IDLE && mode_control_one_r[`B_RX_OFF])
    |=> rx_st_r == uart_pkg::RX_IDLE)
    else $error("receiver started while off");

  a_tick_gap: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE20
    (tick_r && div >= 16'h0002) |=> !tick_r)
    else $error("baud ticks too close");

  a_settle_src: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE16
    o_clock_settled_flag |-> $past(clock_source_select_r[`B_CLK_EN] &&
                                   clock_source_select_r[`B_XTAL_SEL]))
    else $error("clock ready without crystal");

endmodule : fifo_uart_core

`default_nettype wire

//--- pkg/uart_regs.svh
// Register offsets, field positions, reset values and timing counts of the UART core
`ifndef UART_REGS_SVH
`define UART_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define A_HOLDING     5'h00
`define A_IRQ_STAT    5'h02
`define A_LINE_STAT   5'h04
`define A_SYS_STAT    5'h08
`define A_MODE_ONE    5'h09
`define A_MODE_TWO    5'h0a
`define A_LINE_CTRL   5'h0b
`define A_INVERT_CFG  5'h0e
`define A_TRIG_LEVELS 5'h10
`define A_TX_LEVEL    5'h11
`define A_RX_LEVEL    5'h12
`define A_MULT_PREDIV 5'h1a
`define A_BAUD_CFG    5'h1b
`define A_DIV_LOW     5'h1c
`define A_DIV_HIGH    5'h1d
`define A_CLK_SOURCE  5'h1e

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define B_RX_OFF      0
`define B_TX_OFF      1
`define B_FIFO_CLR    1
`define B_OUT_INV     5
`define B_IN_INV      4
`define B_RX_TRIG_IRQ 3
`define B_TX_TRIG_IRQ 4
`define B_TX_EMPTY    5
`define B_RX_EMPTY    6
`define B_PAR_ERR     2
`define B_FRAME_ERR   3
`define B_NOISE       5
`define B_CLK_READY   5
`define B_XTAL_SEL    1
`define B_CLK_EN      4
`define B_CLK_TO_PIN  7
`define B_RATE_2X     4
`define B_RATE_4X     5
`define B_STOP2       2
`define B_PAR_EN      3
`define B_PAR_EVEN    4

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define R_IRQ_STAT    8'h60
`define R_LINE_CTRL   8'h05
`define R_TRIG_LEVELS 8'hff
`define R_MULT_PREDIV 8'h01
`define R_DIV_LOW     8'h01
`define R_CLK_SOURCE  8'h08
`define FIFO_DEPTH    8'h80
`define TRIG_STEP     3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_NS        50
`define SETTLE_NS     100000
`define SETTLE_CYC    ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

//--- pkg/uart_pkg.sv
// Types shared by the UART core
package uart_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : uart_pkg

//--- bench/line_partner.sv
// Far-side serial line model that echoes the device output back
`timescale 1ns/1ps
`default_nettype none

module line_partner (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  always_ff @(posedge i_clk) begin
    o_line <= i_line;
  end
endmodule : line_partner

`default_nettype wire

//--- bench/fifo_uart_core_test.sv
// Self-checking bench for the UART core
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.svh"

module fifo_uart_core_test;
  logic       i_clk   = 1'b0;
  logic       i_rst_n = 1'b0;
  logic       i_wr    = 1'b0;
  logic       i_rd    = 1'b0;
  logic [4:0] i_addr  = 5'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] v;
  wire logic [7:0] rdata;
  wire logic       s_in;
  wire logic       s_out;
  wire logic       settled;
  wire logic       clk_o;
  int              n;
  int              mismatches = 0;
  int              checked    = 0;
  int              i;
  logic [4:0] ra [7] = '{`A_IRQ_STAT, `A_LINE_CTRL, `A_TRIG_LEVELS, `A_MULT_PREDIV,
                         `A_DIV_LOW, `A_CLK_SOURCE, 5'h1f};
  logic [7:0] rv [7] = '{`R_IRQ_STAT, `R_LINE_CTRL, `R_TRIG_LEVELS, `R_MULT_PREDIV,
                         `R_DIV_LOW, `R_CLK_SOURCE, 8'h00};

  fifo_uart_core dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_serial_in(s_in), .o_serial_out(s_out),
    .o_handshake_clock_out_pin(clk_o), .o_clock_settled_flag(settled));
  line_partner far (.i_clk(i_clk), .i_line(s_out), .o_line(s_in));

  initial begin
    forever #25 i_clk = ~i_clk;
  end

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : cmp

  task end_sim;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    #4000000;
    mismatches++;
    end_sim;
  end

  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (i = 0; i < 7; i++) begin
      rd(ra[i], v);
      cmp(v, rv[i], "reset value");
    end
    wr(`A_LINE_CTRL, 8'h03);
    wr(`A_CLK_SOURCE, 8'h10);
    wr(`A_TRIG_LEVELS, 8'h01);
    wr(`A_MODE_ONE, 8'h02);
    for (i = 0; i < 8; i++) wr(`A_HOLDING, 8'(8'h30 + i));
    repeat (40) @(posedge i_clk);
    rd(`A_TX_LEVEL, v);
    cmp(v, 8'h08, "tx level while off");
    rd(`A_IRQ_STAT, v);
    cmp(v & 8'h10, 8'h10, "tx trigger");
    wr(`A_MODE_TWO, 8'h02);
    wr(`A_MODE_TWO, 8'h00);
    rd(`A_TX_LEVEL, v);
    cmp(v, 8'h00, "tx level after clear");
    wr(`A_MODE_ONE, 8'h00);
    for (i = 0; i < 3; i++) wr(`A_HOLDING, 8'(8'h5a + 3 * i));
    i = 0;
    v = 8'h00;
    while (v !== 8'h03 && i < 100) begin
      repeat (16) @(posedge i_clk);
      rd(`A_RX_LEVEL, v);
      i++;
    end
    cmp(v, 8'h03, "rx level");
    for (i = 0; i < 3; i++) begin
      rd(`A_HOLDING, v);
      cmp(v, 8'(8'h5a + 3 * i), "rx data order");
      rd(`A_LINE_STAT, v);
      cmp(v & 8'h2c, 8'h00, "rx status");
    end
    // Line held low by output inversion: ignored while receive is off, framing error once on
    for (i = 0; i < 2; i++) begin
      wr(`A_MODE_ONE, 8'(1 - i));
      wr(`A_INVERT_CFG, 8'h20);
      repeat (200) @(posedge i_clk);
      wr(`A_INVERT_CFG, 8'h00);
      rd(`A_RX_LEVEL, v);
      cmp(v, 8'(i), "rx level after low line");
    end
    rd(`A_HOLDING, v);
    cmp(v, 8'h00, "low line data");
    rd(`A_LINE_STAT, v);
    cmp(v & 8'h2c, 8'h08, "framing error");
    wr(`A_BAUD_CFG, 8'h10);
    wr(`A_HOLDING, 8'hc3);
    repeat (150) @(posedge i_clk);
    rd(`A_HOLDING, v);
    cmp(v, 8'hc3, "2x loopback data");
    rd(`A_IRQ_STAT, v);
    cmp(v & 8'h20, 8'h20, "tx empty");
    wr(`A_DIV_LOW, 8'h02);
    wr(`A_CLK_SOURCE, 8'h90);
    n = 0;
    repeat (32) begin
      @(posedge i_clk);
      #1 n += clk_o;
    end
    cmp(8'(n), 8'h10, "clock-out tick count");
    wr(`A_CLK_SOURCE, 8'h12);
    repeat (`SETTLE_CYC + 100) @(posedge i_clk);
    cmp({7'h00, settled}, 8'h01, "clock ready");
    end_sim;
  end
endmodule : fifo_uart_core_test

`default_nettype wire
